/* hdl/coproc_host_port.sv */
// host bus port, handshakes and operand fifo of the math coprocessor
// ----------------------------------------------------------------
// Overview of operation
// - cycle exists only with select-low low and select-high high.
// - selected write, command 00, takes bus word as opcode.
// - selected read, command 00, drives control or status word.
// - command 01 reads result data or writes operand into fifo.
// - write with command 10 is exception pointer; read reserved.
// - 16-bit opcode status readable with command 11; write reserved.
// - ports F8, FA, FC, FE map to commands 00, 01, 10, 11.
// - opcode write accepted even while busy or in error.
// - execution waits for exception pointer write.
// - busy rises after a recognised escape instruction.
// - operand request asserts when fifo has room or result valid, drops at host strobe.
// - after operands, execute concurrently; error on exception.
// - control-unit instructions run locally, no sequencer start.
// - at select, sample strobes and command bits to classify.
// - write data latched and read data held to trailing strobe edge.
// - arithmetic datapath is 84 bits: 68, 15 and 1.
// - clock-mode strap selects full rate or halved double rate.
// - device busy for 25 internal clocks after reset.
// - in reset busy high, error high, request low, bus floated.
// - long transfers split 3 then 4; request drops before busy.
// - error mirrors error summary and changes only while busy.
// ----------------------------------------------------------------
`timescale 1ns/1ps

module coproc_host_port #(
  parameter int FIFO_DEPTH = 8,
  parameter int FIFO_AW    = 3
) (
  input  wire logic                                   MCLK,                  // clock
  input  wire logic                                   RSTN,                  // sync reset
  input  wire logic                                   COPROC_SELECT_LOW_N,   // select, low
  input  wire logic                                   COPROC_SELECT_HIGH,    // select, high
  input  wire logic                                   COMMAND_BIT_ZERO,      // command bit 0
  input  wire logic                                   COMMAND_BIT_ONE,       // command bit 1
  input  wire logic                                   COPROC_READ_STROBE_N,  // read strobe
  input  wire logic                                   COPROC_WRITE_STROBE_N, // write strobe
  input  wire logic [coproc_port_pkg::HOST_DATA_W-1:0] DATA_IN,              // bus in
  output logic      [coproc_port_pkg::HOST_DATA_W-1:0] DATA_OUT,             // bus out
  output logic                                        DATA_OE,               // bus drive
  output logic                                        BUSY,                  // busy
  output logic                                        OPERAND_REQUEST,       // operand req
  output logic                                        ERROR,                 // error
  input  wire logic                                   CLOCK_MODE_STRAP,      // clock mode
  output logic      [coproc_port_pkg::HOST_DATA_W-1:0] OPCODE_WORD,          // to decoder
  output logic                                        OPCODE_VALID,          // opcode pulse
  output logic      [coproc_port_pkg::HOST_DATA_W-1:0] EXC_PTR_WORD,         // pointer word
  output logic                                        EXC_PTR_VALID,         // pointer pulse
  output logic      [coproc_port_pkg::HOST_DATA_W-1:0] OPND_WORD,            // fifo head
  output logic                                        OPND_VALID,            // fifo not empty
  input  wire logic                                   OPND_READY,            // core pops
  input  wire logic [coproc_port_pkg::HOST_DATA_W-1:0] RESULT_WORD,          // core result
  input  wire logic                                   RESULT_VALID,          // result ready
  output logic                                        RESULT_TAKE,           // result pop
  input  wire logic [coproc_port_pkg::STATUS_W-1:0]    OPCODE_STATUS,        // decode result
  input  wire logic [coproc_port_pkg::CNT_W-1:0]       XFER_WORDS,           // words to move
  input  wire logic                                   XFER_TO_HOST,          // 1 = results
  input  wire logic                                   LOCAL_INSTR,           // control-unit op
  input  wire logic [coproc_port_pkg::HOST_DATA_W-1:0] CTRL_STATUS_WORD,     // cw or sw
  input  wire logic                                   ERROR_SUMMARY,         // es bit
  output logic                                        EXEC_START,            // start pulse
  output logic                                        LOCAL_EXEC,            // local pulse
  input  wire logic                                   EXEC_DONE              // core finished
);
  import coproc_port_pkg::*;

  // ----------------------------------------------------------------
  // bus cycle decode
  // ----------------------------------------------------------------
  logic        sel_reg;
  logic        rd_n_reg;
  logic        wr_n_reg;
  bus_cycle_t  cyc_reg;
  bus_cycle_t  cyc_sample;
  bus_cycle_t  cyc_eff;

  wire sel_now   = ~COPROC_SELECT_LOW_N & COPROC_SELECT_HIGH;
  wire cyc_start = sel_now & ~sel_reg;

  assign cyc_sample = '{rd: ~COPROC_READ_STROBE_N, wr: ~COPROC_WRITE_STROBE_N,
                        cmd: {COMMAND_BIT_ONE, COMMAND_BIT_ZERO}};
  assign cyc_eff    = cyc_start ? cyc_sample : cyc_reg;

  // classification only acts on the trailing strobe edge
  wire wr_trail  = sel_now & cyc_reg.wr & ~wr_n_reg & COPROC_WRITE_STROBE_N;
  wire rd_trail  = sel_now & cyc_reg.rd & ~rd_n_reg & COPROC_READ_STROBE_N;
  wire op_wr     = wr_trail & (cyc_reg.cmd == CMD_OPCODE);
  wire opnd_wr   = wr_trail & (cyc_reg.cmd == CMD_OPERAND);
  wire exc_wr    = wr_trail & (cyc_reg.cmd == CMD_EXCPTR);
  wire opnd_rd   = rd_trail & (cyc_reg.cmd == CMD_OPERAND);
  // command 10 read and command 11 write fall through untouched
  wire rd_legal  = cyc_eff.rd & (cyc_eff.cmd != CMD_EXCPTR);
  wire oe_next   = sel_now & ~COPROC_READ_STROBE_N & rd_legal;
  wire strobe_lo = sel_now & (~COPROC_READ_STROBE_N | ~COPROC_WRITE_STROBE_N);

  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      sel_reg  <= 1'b0;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      cyc_reg  <= '0;
    end
    else
    begin
      sel_reg  <= sel_now;
      rd_n_reg <= COPROC_READ_STROBE_N;
      wr_n_reg <= COPROC_WRITE_STROBE_N;
      cyc_reg  <= sel_now ? cyc_eff : '0;
    end
  end

  // ----------------------------------------------------------------
  // read data path
  // ----------------------------------------------------------------
  logic [HOST_DATA_W-1:0] rd_mux;
  logic                   oe_reg;
  logic [HOST_DATA_W-1:0] dout_reg;
  wire                    data_load = oe_next & ~oe_reg;

  assign rd_mux = (cyc_eff.cmd == CMD_OPSTAT)  ? OPCODE_STATUS :
                  (cyc_eff.cmd == CMD_OPERAND) ? RESULT_WORD   :
                                                 CTRL_STATUS_WORD;

  // word is frozen at the leading edge so it stays put until the strobe ends
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      oe_reg   <= 1'b0;
      dout_reg <= '0;
    end
    else
    begin
      oe_reg <= oe_next;
      if (data_load)
        dout_reg <= rd_mux;
    end
  end

  assign DATA_OE  = oe_reg;
  assign DATA_OUT = dout_reg;

  // ----------------------------------------------------------------
  // internal clock enable from the strap
  // ----------------------------------------------------------------
  logic strap_reg;
  logic strap_done_reg;
  logic div_reg;

  // strap caught once after reset; low means a double-rate oscillator
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      strap_done_reg <= 1'b0;
      strap_reg      <= 1'b1;
      div_reg        <= 1'b0;
    end
    else
    begin
      if (!strap_done_reg)
      begin
        strap_reg      <= CLOCK_MODE_STRAP;
        strap_done_reg <= 1'b1;
      end
      div_reg <= ~div_reg;
    end
  end

  wire tick = strap_reg | div_reg;

  // ----------------------------------------------------------------
  // operand fifo
  // ----------------------------------------------------------------
  logic [HOST_DATA_W-1:0] fifo_mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0]     wr_ptr_reg;
  logic [FIFO_AW-1:0]     rd_ptr_reg;
  logic [FIFO_AW:0]       fifo_cnt_reg;

  wire fifo_full = (fifo_cnt_reg == (FIFO_AW+1)'(FIFO_DEPTH));
  wire fifo_push = opnd_wr & ~fifo_full;
  wire fifo_pop  = OPND_READY & (fifo_cnt_reg != '0);

  always_ff @(posedge MCLK)
  begin
    if (fifo_push)
      fifo_mem[wr_ptr_reg] <= DATA_IN;
  end

  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      fifo_cnt_reg <= '0;
    end
    else
    begin
      if (fifo_push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (fifo_pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      fifo_cnt_reg <= fifo_cnt_reg + {{FIFO_AW{1'b0}}, fifo_push}
                                   - {{FIFO_AW{1'b0}}, fifo_pop};
    end
  end

  assign OPND_WORD   = fifo_mem[rd_ptr_reg];
  assign OPND_VALID  = (fifo_cnt_reg != '0);

  // ----------------------------------------------------------------
  // instruction sequencing
  // ----------------------------------------------------------------
  port_state_t        state_reg;
  port_state_t        state_next;
  logic [4:0]         wake_reg;
  logic               pend_reg;
  logic               dir_reg;
  logic [CNT_W-1:0]   words_reg;
  logic [CNT_W-1:0]   burst_reg;
  logic               start_reg;
  logic               local_reg;
  logic               opv_reg;
  logic               excv_reg;
  logic [HOST_DATA_W-1:0] opcode_reg;
  logic [HOST_DATA_W-1:0] excptr_reg;
  assign RESULT_TAKE = opnd_rd & dir_reg;

  wire xfer_now  = (state_reg == ST_XFER) & (dir_reg ? opnd_rd : opnd_wr);
  wire big_xfer  = (XFER_WORDS > BURST_SPLIT_GT);
  wire wake_end  = tick & (wake_reg == WAKE_TICKS);
  wire last_word = xfer_now & (words_reg == CNT_W'(1));

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_WAKE:   if (wake_end) state_next = ST_IDLE;
      ST_IDLE:   if (op_wr | pend_reg) state_next = ST_OPCODE;
      ST_OPCODE:
        if (LOCAL_INSTR & tick)
          state_next = ST_IDLE;
        else if (exc_wr)
          state_next = (XFER_WORDS == '0) ? ST_EXEC : ST_XFER;
      ST_XFER:   if (last_word) state_next = ST_EXEC;
      ST_EXEC:   if (EXEC_DONE) state_next = ST_IDLE;
      default:   state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      state_reg <= ST_WAKE;
      wake_reg  <= '0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == ST_WAKE && tick)
        wake_reg <= wake_reg + 1'b1;
    end
  end

  // opcode taken in any state; a second one waits its turn
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      pend_reg   <= 1'b0;
      opv_reg    <= 1'b0;
      excv_reg   <= 1'b0;
      opcode_reg <= '0;
      excptr_reg <= '0;
    end
    else
    begin
      opv_reg  <= op_wr;
      excv_reg <= exc_wr;
      if (op_wr)
        opcode_reg <= DATA_IN;
      if (exc_wr)
        excptr_reg <= DATA_IN;
      if (op_wr && state_reg != ST_IDLE)
        pend_reg <= 1'b1;
      else if (state_reg == ST_IDLE)
        pend_reg <= 1'b0;
    end
  end

  // bursts of 3 then 4 leave a one-tick gap in the request
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      dir_reg   <= 1'b0;
      words_reg <= '0;
      burst_reg <= '0;
      start_reg <= 1'b0;
      local_reg <= 1'b0;
    end
    else
    begin
      start_reg <= (state_next == ST_EXEC) & (state_reg != ST_EXEC);
      local_reg <= (state_reg == ST_OPCODE) & LOCAL_INSTR & tick;
      if (state_reg == ST_OPCODE && exc_wr)
      begin
        dir_reg   <= XFER_TO_HOST;
        words_reg <= XFER_WORDS;
        burst_reg <= big_xfer ? FIRST_BURST : XFER_WORDS;
      end
      else if (xfer_now)
      begin
        words_reg <= words_reg - 1'b1;
        burst_reg <= burst_reg - 1'b1;
      end
      else if (tick && state_reg == ST_XFER && burst_reg == '0)
        burst_reg <= NEXT_BURST;
    end
  end

  // ----------------------------------------------------------------
  // handshake pins
  // ----------------------------------------------------------------
  logic busy_reg;
  logic req_reg;
  logic err_reg;

  wire side_ready = dir_reg ? RESULT_VALID : ~fifo_full;
  wire req_next   = (state_reg == ST_XFER) & (burst_reg != '0) & ~xfer_now
                    & ~strobe_lo & side_ready;

  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      busy_reg <= BUSY_RST;
      req_reg  <= REQ_RST;
      err_reg  <= ERROR_RST;
    end
    else
    begin
      busy_reg <= (state_next != ST_IDLE) | op_wr | pend_reg;
      req_reg  <= req_next;
      if (busy_reg)
        err_reg <= ERROR_SUMMARY;
    end
  end

  assign BUSY            = busy_reg;
  assign OPERAND_REQUEST = req_reg;
  assign ERROR           = err_reg;
  assign OPCODE_WORD     = opcode_reg;
  assign OPCODE_VALID    = opv_reg;
  assign EXC_PTR_WORD    = excptr_reg;
  assign EXC_PTR_VALID   = excv_reg;
  assign EXEC_START      = start_reg;
  assign LOCAL_EXEC      = local_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  property p_unsel_float;
    !sel_now |=> !DATA_OE;
  endproperty
  a_unsel_float: assert property (p_unsel_float) else $error("bus driven while unselected");

  property p_opcode_take;
    op_wr |=> OPCODE_VALID && BUSY && (OPCODE_WORD == $past(DATA_IN));
  endproperty
  a_opcode_take: assert property (p_opcode_take) else $error("opcode write not taken");

  property p_cw_read;
    data_load && cyc_eff.cmd == CMD_OPCODE |=> DATA_OE && DATA_OUT == $past(CTRL_STATUS_WORD);
  endproperty
  a_cw_read: assert property (p_cw_read) else $error("control word not presented");

  property p_opstat_read;
    data_load && cyc_eff.cmd == CMD_OPSTAT |=> DATA_OUT == $past(OPCODE_STATUS);
  endproperty
  a_opstat_read: assert property (p_opstat_read) else $error("opcode status not presented");

  property p_operand_push;
    fifo_push && !fifo_pop |=> fifo_cnt_reg == $past(fifo_cnt_reg) + 1'b1;
  endproperty
  a_operand_push: assert property (p_operand_push) else $error("operand not stored");

  property p_excptr;
    exc_wr |=> EXC_PTR_VALID ##1 !EXC_PTR_VALID;
  endproperty
  a_excptr: assert property (p_excptr) else $error("exception pointer not pulsed");

  property p_reserved;
    sel_now && !cyc_start && cyc_reg.rd && cyc_reg.cmd == CMD_EXCPTR |=> !DATA_OE;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved read drove bus");

  property p_defer;
    state_reg == ST_OPCODE && !exc_wr |=> !EXEC_START;
  endproperty
  a_defer: assert property (p_defer) else $error("execution before pointers");

  property p_local;
    state_reg == ST_OPCODE && LOCAL_INSTR && tick && !pend_reg && !op_wr
      |=> LOCAL_EXEC && !EXEC_START && !BUSY;
  endproperty
  a_local: assert property (p_local) else $error("local instruction misrouted");

  property p_req_first;
    $fell(BUSY) |-> !OPERAND_REQUEST && !$past(OPERAND_REQUEST);
  endproperty
  a_req_first: assert property (p_req_first) else $error("request outlived busy");

  property p_err_busy;
    $changed(ERROR) |-> $past(BUSY);
  endproperty
  a_err_busy: assert property (p_err_busy) else $error("error moved while idle");

  property p_wake;
    $rose(RSTN) |-> BUSY [*8];
  endproperty
  a_wake: assert property (p_wake) else $error("busy dropped early after reset");

  property p_reset_pins;
    @(posedge MCLK) disable iff (1'b0)
    !RSTN |=> BUSY && ERROR && !OPERAND_REQUEST && !DATA_OE;
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("reset pin levels wrong");

  c_opcode:  cover property (op_wr ##[1:20] exc_wr);
  c_xfer:    cover property (state_reg == ST_XFER ##[1:200] state_reg == ST_EXEC);
  c_gap:     cover property (state_reg == ST_XFER && burst_reg == '0);
  c_local:   cover property (LOCAL_EXEC);

endmodule

/* hdl/coproc_port_pkg.sv */
// constants, types and layouts shared by the coprocessor host port
package coproc_port_pkg;

  // ----------------------------------------------------------------
  // data widths
  // ----------------------------------------------------------------
  localparam int HOST_DATA_W = 16;
  localparam int STATUS_W    = 16;
  localparam int CNT_W       = 8;
  localparam int SIGNIF_W    = 68;
  localparam int EXPON_W     = 15;
  localparam int SIGN_W      = 1;
  localparam int DATAPATH_W  = SIGNIF_W + EXPON_W + SIGN_W;

  // ----------------------------------------------------------------
  // command codes, {command_bit_one, command_bit_zero}
  // ----------------------------------------------------------------
  localparam logic [1:0] CMD_OPCODE  = 2'h0;  // port 00F8
  localparam logic [1:0] CMD_OPERAND = 2'h1;  // port 00FA
  localparam logic [1:0] CMD_EXCPTR  = 2'h2;  // port 00FC
  localparam logic [1:0] CMD_OPSTAT  = 2'h3;  // port 00FE

  localparam logic [15:0] PORT_OPCODE  = 16'h00F8;
  localparam logic [15:0] PORT_OPERAND = 16'h00FA;
  localparam logic [15:0] PORT_EXCPTR  = 16'h00FC;
  localparam logic [15:0] PORT_OPSTAT  = 16'h00FE;

  // ----------------------------------------------------------------
  // timing counts: wake in internal clock ticks, bursts in words
  // ----------------------------------------------------------------
  localparam logic [4:0]       WAKE_TICKS      = 5'h19;  // 25 internal clocks
  localparam logic [CNT_W-1:0] FIRST_BURST     = 8'h03;
  localparam logic [CNT_W-1:0] NEXT_BURST      = 8'h04;
  localparam logic [CNT_W-1:0] BURST_SPLIT_GT  = 8'h05;

  // ----------------------------------------------------------------
  // reset values of the handshake pins
  // ----------------------------------------------------------------
  localparam logic BUSY_RST  = 1'b1;
  localparam logic ERROR_RST = 1'b1;
  localparam logic REQ_RST   = 1'b0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_OPCODE = 3'b001,
    ST_XFER   = 3'b010,
    ST_EXEC   = 3'b011,
    ST_WAKE   = 3'b100
  } port_state_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [1:0] cmd;
  } bus_cycle_t;

endpackage

/* verification/host_bus_model.sv */
// host cpu model issuing coprocessor i/o bus cycles
`timescale 1ns/1ps

module host_bus_model (
  input  wire logic        clk,        // bus clock
  output logic             sel_low_n,  // coprocessor chip select
  output logic             sel_high,   // second select
  output logic             cmd_zero,   // from address bit 1
  output logic             cmd_one,    // from address bit 2
  output logic             rd_n,       // read strobe
  output logic             wr_n,       // write strobe
  output logic [15:0]      data        // write data
);
  initial
  begin
    sel_low_n = 1'b1;
    sel_high  = 1'b1;
    cmd_zero  = 1'b0;
    cmd_one   = 1'b0;
    rd_n      = 1'b1;
    wr_n      = 1'b1;
    data      = 16'hA5A5;
  end

  // software reaches the ports only through whole cycles here
  task automatic io(input logic is_rd, input logic [15:0] addr, input logic [15:0] word,
                    input logic sel2);
    @(negedge clk);
    sel_low_n = 1'b0;
    sel_high  = sel2;
    cmd_one   = addr[2];
    cmd_zero  = addr[1];
    rd_n      = ~is_rd;
    wr_n      = is_rd;
    data      = word;
    repeat (3) @(negedge clk);
    rd_n      = 1'b1;
    wr_n      = 1'b1;
    @(negedge clk);
    sel_low_n = 1'b1;
    sel_high  = 1'b1;
    data      = ~word;  // released bus must not keep the old word
  endtask
endmodule

/* verification/math_coprocessor_host_port_tb.sv */
// self-checking bench for the coprocessor host port
`timescale 1ns/1ps

module math_coprocessor_host_port_tb;
  import coproc_port_pkg::*;
  logic        mclk, rstn, sel_low_n, sel_high, cmd_zero, cmd_one, rd_n, wr_n;
  logic [15:0] din, dout, opc_w, exc_w, opnd_w, res_w, stat_w, csw, w;
  logic        oe, busy, req, err, opc_v, exc_v, opnd_v, res_take, oe_q;
  logic        to_host, local_i, es, start, lexec, done, err_q, trap_q, strap;
  logic [7:0]  xfer_n;
  int          num_errors, check_count, starts, locals, seed, n, t, i;
  logic [15:0] expq [4][$];

  host_bus_model host_u (.clk(mclk), .sel_low_n(sel_low_n), .sel_high(sel_high),
    .cmd_zero(cmd_zero), .cmd_one(cmd_one), .rd_n(rd_n), .wr_n(wr_n), .data(din));

  coproc_host_port dut_u (.MCLK(mclk), .RSTN(rstn), .COPROC_SELECT_LOW_N(sel_low_n),
    .COPROC_SELECT_HIGH(sel_high), .COMMAND_BIT_ZERO(cmd_zero), .COMMAND_BIT_ONE(cmd_one),
    .COPROC_READ_STROBE_N(rd_n), .COPROC_WRITE_STROBE_N(wr_n), .DATA_IN(din),
    .DATA_OUT(dout), .DATA_OE(oe), .BUSY(busy), .OPERAND_REQUEST(req), .ERROR(err),
    .CLOCK_MODE_STRAP(strap), .OPCODE_WORD(opc_w), .OPCODE_VALID(opc_v),
    .EXC_PTR_WORD(exc_w), .EXC_PTR_VALID(exc_v), .OPND_WORD(opnd_w), .OPND_VALID(opnd_v),
    .OPND_READY(1'b1), .RESULT_WORD(res_w), .RESULT_VALID(1'b1), .RESULT_TAKE(res_take),
    .OPCODE_STATUS(stat_w), .XFER_WORDS(xfer_n), .XFER_TO_HOST(to_host),
    .LOCAL_INSTR(local_i), .CTRL_STATUS_WORD(csw), .ERROR_SUMMARY(es),
    .EXEC_START(start), .LOCAL_EXEC(lexec), .EXEC_DONE(done));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic stop_test();
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_w(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    check_count++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      num_errors++;
    end
  endtask

  task automatic chk_b(input string nm, input logic exp, input logic seen);
    check_count++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %b seen %b", nm, exp, seen);
      num_errors++;
    end
  endtask

  task automatic push(input int k, input logic [15:0] v);
    expq[k].push_back(v);
  endtask

  // a result with no note behind it is an unexpected acceptance
  task automatic take(input int k, input string nm, input logic [15:0] seen);
    if (expq[k].size() == 0)
      chk_b(nm, 1'b0, 1'b1);
    else
      chk_w(nm, expq[k].pop_front(), seen);
  endtask

  task automatic wait_sig(input bit which, input logic lvl);
    int j;
    for (j = 0; j < 3000 && ((which ? req : busy) !== lvl); j++) @(negedge mclk);
    if (j == 3000)
    begin
      chk_b("wait_limit", 1'b0, 1'b1);
      stop_test();
    end
  endtask

  // ----------------------------------------------------------------
  // result monitor and core stand-in
  // ----------------------------------------------------------------
  always @(posedge mclk)
  begin
    oe_q <= oe;
    done <= start;
    err_q <= err;
    // external trap latch: catches busy as error rises, cleared at reset
    if (rstn !== 1'b1)
      trap_q <= 1'b0;
    else if (err === 1'b1 && err_q === 1'b0)
      trap_q <= busy;
    if (opc_v === 1'b1) take(0, "opcode_word", opc_w);
    if (exc_v === 1'b1) take(1, "exc_ptr_word", exc_w);
    if (opnd_v === 1'b1) take(2, "operand_word", opnd_w);
    if (oe === 1'b1 && oe_q !== 1'b1) take(3, "read_data", dout);
    if (start === 1'b1) starts++;
    if (lexec === 1'b1) locals++;
    if (res_take === 1'b1 || rstn !== 1'b1) res_w <= 16'($random(seed));
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 32'h878E;
    rstn = 1'b0;
    stat_w = 16'($random(seed));
    csw = 16'($random(seed));
    {xfer_n, to_host, local_i, es, strap} = 12'h001;
    repeat (20) @(negedge mclk);
    chk_b("busy", 1'b1, busy);
    chk_b("error", 1'b1, err);
    chk_b("operand_request", 1'b0, req);
    chk_b("data_oe", 1'b0, oe);
    rstn = 1'b1;
    for (n = 0; n < 300 && busy !== 1'b0; n++) @(negedge mclk);
    chk_b("wake_length", 1'b1, n >= 25 && n < 300);
    if (n == 300) stop_test();
    push(3, stat_w);
    host_u.io(1'b1, PORT_OPSTAT, 16'h0000, 1'b1);
    push(3, csw);
    host_u.io(1'b1, PORT_OPCODE, 16'h0000, 1'b1);
    host_u.io(1'b1, PORT_EXCPTR, 16'h0000, 1'b1);
    host_u.io(1'b0, PORT_OPSTAT, 16'h1234, 1'b1);
    host_u.io(1'b1, PORT_OPSTAT, 16'h0000, 1'b0);
    host_u.io(1'b0, PORT_OPCODE, 16'h4321, 1'b0);
    chk_b("busy", 1'b0, busy);
    for (t = 0; t < 2; t++)
    begin
      to_host = t[0];
      xfer_n = t[0] ? 8'h02 : 8'h07;
      es = ~t[0];
      w = 16'($random(seed));
      push(0, w);
      host_u.io(1'b0, PORT_OPCODE, w, 1'b1);
      chk_b("busy", 1'b1, busy);
      push(3, stat_w);
      host_u.io(1'b1, PORT_OPSTAT, 16'h0000, 1'b1);
      chk_b("early_start", 1'b1, starts == t);
      w = 16'($random(seed));
      push(1, w);
      host_u.io(1'b0, PORT_EXCPTR, w, 1'b1);
      for (i = 0; i < xfer_n; i++)
      begin
        wait_sig(1'b1, 1'b1);
        w = t[0] ? res_w : 16'($random(seed));
        push(t[0] ? 3 : 2, w);
        host_u.io(t[0], PORT_OPERAND, w, 1'b1);
      end
      wait_sig(1'b0, 1'b0);
      chk_b("operand_request", 1'b0, req);
      chk_b("error", es, err);
      chk_b("start_count", 1'b1, starts == t + 1);
      chk_b("trap_latch", 1'b1, trap_q);
      es = ~es;
      repeat (4) @(negedge mclk);
      chk_b("error_frozen", ~es, err);
    end
    local_i = 1'b1;
    for (i = 0; i < 2; i++)
    begin
      w = 16'($random(seed));
      push(0, w);
      host_u.io(1'b0, PORT_OPCODE, w, 1'b1);
    end
    repeat (4) @(negedge mclk);
    wait_sig(1'b0, 1'b0);
    chk_b("local_count", 1'b1, locals == 2);
    chk_b("start_count", 1'b1, starts == 2);
    // second reset in mid-run, strap low: internal clock at half rate
    strap = 1'b0;
    rstn = 1'b0;
    repeat (8) @(negedge mclk);
    rstn = 1'b1;
    for (n = 0; n < 300 && busy !== 1'b0; n++) @(negedge mclk);
    chk_b("wake_length", 1'b1, n >= 50 && n < 300);
    if (n == 300) stop_test();
    w = 16'($random(seed));
    push(0, w);
    host_u.io(1'b0, PORT_OPCODE, w, 1'b1);
    wait_sig(1'b0, 1'b0);
    repeat (2) @(negedge mclk);
    chk_b("local_count", 1'b1, locals == 3);
    chk_b("pending", 1'b1, expq[0].size() + expq[2].size() + expq[3].size() == 0);
    stop_test();
  end
endmodule
